// ===== core/mdu_cfg.svh
// Purpose: Offsets, field positions and timing counts of the multiply/divide unit
// Assumes: Register file reached by the core's byte-wide register port
// Notes: Definitions only
`ifndef MDU_CFG_SVH
`define MDU_CFG_SVH
`define MDU_OFS_OP0 8'h00
`define MDU_OFS_OP1 8'h01
`define MDU_OFS_OP2 8'h02
`define MDU_OFS_OP3 8'h03
`define MDU_OFS_OP4 8'h04
`define MDU_OFS_OP5 8'h05
`define MDU_OFS_CTRL 8'h06
`define MDU_OFS_SCR_A 8'h14
`define MDU_OFS_SCR_B 8'h15
`define MDU_BANK 4'hE
`define MDU_CTRL_DIV_BIT 0
`define MDU_CTRL_START_BIT 1
`define MDU_CTRL_BUSY_BIT 6
`define MDU_CTRL_DONE_BIT 7
`define MDU_MUL_CYCLES 5'h11
`define MDU_DIV_CYCLES 5'h14
`endif

// ===== core/mdu_pkg.sv
// Purpose: Types shared by the multiply/divide unit
// Assumes: Nothing
// Notes: Bus request carried as one packed struct
package mdu_pkg;
    typedef struct packed {
        logic [3:0] bank;
        logic [7:0] addr;
        logic wr;
        logic rd;
        logic [7:0] wdata;
    } mdu_req_s;
    typedef enum logic [2:0] {
        MDU_IDLE = 3'b001,
        MDU_MUL = 3'b010,
        MDU_DIV = 3'b100
    } mdu_state_e;
endpackage

// ===== core/mdu_unit.sv
// Contract
// - All operands and results are unsigned; no sign handling anywhere.
// - Multiply takes two 16-bit operands and keeps the full 32-bit product.
// - Divide takes 32-bit dividend, 16-bit divisor; gives 16-bit quotient and remainder.
// - Reachable only through direct register reads and writes.
// - Bank E: data bytes 00-05, control 06, scratch bytes 14 and 15.
// - Multiply result delivered 17 clocks after start.
// - Divide result delivered 20 clocks after start.
// Purpose: Register-mapped unsigned 16x16 multiplier and 32/16 divider
// Assumes: Register port synchronous to i_clock; one access per cycle
// Notes: Multiply: op1:op0 * op3:op2 -> op3..op0 product. Divide: op3..op0 / op5:op4 ->
//        quotient op1:op0, remainder op3:op2. Divide by zero gives quotient equal to the inverted old op3:op2 and remainder equal to the old op1:op0.
`timescale 1ns/1ps
`include "mdu_cfg.svh"
module mdu_unit
    import mdu_pkg::*;
(
    input wire logic i_clock,
    input wire logic i_rst,
    input wire mdu_req_s i_req,
    output logic [7:0] o_rdata,
    output logic o_busy,
    output logic o_done
);
    logic [7:0] regs_ff [0:5];
    logic [7:0] scr_a_ff;
    logic [7:0] scr_b_ff;
    logic div_sel_ff;
    logic done_ff;
    mdu_state_e state_ff;
    logic [4:0] cnt_ff;
    logic [31:0] acc_ff;
    logic [15:0] mcand_ff;
    logic [15:0] dvs_ff;
    logic [15:0] mul_hi;
    logic [16:0] mul_sum;
    logic [16:0] rem_sh;
    logic [16:0] rem_diff;
    logic hit;
    logic start;
    logic finish;
    logic [7:0] nxt_rdata;
    logic [4:0] chk_len_ff;

    assign hit = (i_req.bank == `MDU_BANK);
    assign start = hit && i_req.wr && (i_req.addr == `MDU_OFS_CTRL)
        && i_req.wdata[`MDU_CTRL_START_BIT] && (state_ff == MDU_IDLE);
    // Shift-add multiply: one partial product per cycle, 16 steps
    assign mul_sum = {1'b0, acc_ff[31:16]} + (acc_ff[0] ? {1'b0, mcand_ff} : 17'h00000);
    assign mul_hi = mul_sum[16:1];
    // Restoring divide: one quotient bit per cycle, 16 steps
    assign rem_sh = {acc_ff[31:15]};
    assign rem_diff = rem_sh - {1'b0, dvs_ff};

    // Busy/done timing: work steps run first, remaining counts are idle padding to the fixed latency
    assign finish = (state_ff != MDU_IDLE) && (cnt_ff == 5'h01);

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            state_ff <= MDU_IDLE;
            cnt_ff <= 5'h00;
        end else begin
            unique case (state_ff)
                MDU_IDLE: begin
                    if (start) begin
                        state_ff <= i_req.wdata[`MDU_CTRL_DIV_BIT] ? MDU_DIV : MDU_MUL;
                        cnt_ff <= i_req.wdata[`MDU_CTRL_DIV_BIT] ? `MDU_DIV_CYCLES : `MDU_MUL_CYCLES;
                    end
                end
                MDU_MUL, MDU_DIV: begin
                    cnt_ff <= cnt_ff - 5'h01;
                    if (cnt_ff == 5'h01) begin
                        state_ff <= MDU_IDLE;
                    end
                end
                default: begin
                    state_ff <= MDU_IDLE;
                end
            endcase
        end
    end

    // Datapath; operands latched at start so later writes cannot corrupt the run
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            acc_ff <= 32'h00000000;
            mcand_ff <= 16'h0000;
            dvs_ff <= 16'h0000;
        end else if (start) begin
            if (i_req.wdata[`MDU_CTRL_DIV_BIT]) begin
                acc_ff <= {regs_ff[3], regs_ff[2], regs_ff[1], regs_ff[0]};
                dvs_ff <= {regs_ff[5], regs_ff[4]};
            end else begin
                acc_ff <= {16'h0000, regs_ff[1], regs_ff[0]};
                mcand_ff <= {regs_ff[3], regs_ff[2]};
            end
        end else if (state_ff == MDU_MUL && cnt_ff > 5'h01) begin
            acc_ff <= {mul_hi, mul_sum[0], acc_ff[15:1]};
        end else if (state_ff == MDU_DIV && cnt_ff > 5'h04) begin
            if (!rem_diff[16]) begin
                acc_ff <= {rem_diff[15:0], acc_ff[14:0], 1'b1};
            end else begin
                acc_ff <= {acc_ff[30:0], 1'b0};
            end
        end
    end

    // Data bytes: core writes, results overwrite on completion
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            for (int i = 0; i < 6; i++) begin
                regs_ff[i] <= 8'h00;
            end
        end else if (finish) begin
            if (state_ff == MDU_DIV) begin
                regs_ff[0] <= acc_ff[7:0];
                regs_ff[1] <= acc_ff[15:8];
                regs_ff[2] <= acc_ff[23:16];
                regs_ff[3] <= acc_ff[31:24];
            end else begin
                regs_ff[0] <= acc_ff[7:0];
                regs_ff[1] <= acc_ff[15:8];
                regs_ff[2] <= acc_ff[23:16];
                regs_ff[3] <= acc_ff[31:24];
            end
        end else if (hit && i_req.wr && i_req.addr <= `MDU_OFS_OP5) begin
            regs_ff[i_req.addr[2:0]] <= i_req.wdata;
        end
    end

    // Control and scratch bytes
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            div_sel_ff <= 1'b0;
            done_ff <= 1'b0;
            scr_a_ff <= 8'h00;
            scr_b_ff <= 8'h00;
        end else begin
            if (start) begin
                div_sel_ff <= i_req.wdata[`MDU_CTRL_DIV_BIT];
                done_ff <= 1'b0;
            end else if (finish) begin
                done_ff <= 1'b1;
            end else if (hit && i_req.wr && i_req.addr == `MDU_OFS_CTRL && state_ff == MDU_IDLE) begin
                div_sel_ff <= i_req.wdata[`MDU_CTRL_DIV_BIT];
            end
            if (hit && i_req.wr && i_req.addr == `MDU_OFS_SCR_A) begin
                scr_a_ff <= i_req.wdata;
            end
            if (hit && i_req.wr && i_req.addr == `MDU_OFS_SCR_B) begin
                scr_b_ff <= i_req.wdata;
            end
        end
    end

    // Read mux; registered so the answer follows the read by one clock
    always_comb begin
        nxt_rdata = 8'h00;
        if (hit && i_req.rd) begin
            if (i_req.addr <= `MDU_OFS_OP5) begin
                nxt_rdata = regs_ff[i_req.addr[2:0]];
            end else if (i_req.addr == `MDU_OFS_CTRL) begin
                nxt_rdata[`MDU_CTRL_DIV_BIT] = div_sel_ff;
                nxt_rdata[`MDU_CTRL_BUSY_BIT] = (state_ff != MDU_IDLE);
                nxt_rdata[`MDU_CTRL_DONE_BIT] = done_ff;
            end else if (i_req.addr == `MDU_OFS_SCR_A) begin
                nxt_rdata = scr_a_ff;
            end else if (i_req.addr == `MDU_OFS_SCR_B) begin
                nxt_rdata = scr_b_ff;
            end
        end
    end

    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            o_rdata <= 8'h00;
            o_busy <= 1'b0;
            o_done <= 1'b0;
        end else begin
            o_rdata <= nxt_rdata;
            o_busy <= (state_ff != MDU_IDLE) ? !finish : start;
            o_done <= finish ? 1'b1 : (start ? 1'b0 : done_ff);
        end
    end

    // Assertion helper: cycles since start, counted apart from the run counter
    always_ff @(posedge i_clock or posedge i_rst) begin
        if (i_rst) begin
            chk_len_ff <= 5'h00;
        end else if (start) begin
            chk_len_ff <= 5'h01;
        end else if (state_ff != MDU_IDLE) begin
            chk_len_ff <= chk_len_ff + 5'h01;
        end
    end

    sequence mul_start_s;
        start && !i_req.wdata[`MDU_CTRL_DIV_BIT];
    endsequence
    sequence div_start_s;
        start && i_req.wdata[`MDU_CTRL_DIV_BIT];
    endsequence

    mul_latency_a: assert property (@(posedge i_clock) disable iff (i_rst)
        mul_start_s |-> ##17 finish) else $error("Multiply did not finish in 17 cycles");
    div_latency_a: assert property (@(posedge i_clock) disable iff (i_rst)
        div_start_s |-> ##20 finish) else $error("Divide did not finish in 20 cycles");
    // Independent count also catches a finish that comes early
    run_length_a: assert property (@(posedge i_clock) disable iff (i_rst)
        finish |-> chk_len_ff == (div_sel_ff ? `MDU_DIV_CYCLES : `MDU_MUL_CYCLES))
        else $error("Run ended at wrong cycle count");
    mul_result_a: assert property (@(posedge i_clock) disable iff (i_rst)
        mul_start_s |-> ##18 ({regs_ff[3], regs_ff[2], regs_ff[1], regs_ff[0]}
            == 32'($past({regs_ff[1], regs_ff[0]}, 18)) * 32'($past({regs_ff[3], regs_ff[2]}, 18))))
        else $error("Multiply product wrong");
    div_quot_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (div_start_s and (({regs_ff[5], regs_ff[4]} != 16'h0000)
        && ({regs_ff[3], regs_ff[2]} < {regs_ff[5], regs_ff[4]})))
        |-> ##21 ({regs_ff[1], regs_ff[0]} == 16'($past({regs_ff[3], regs_ff[2], regs_ff[1], regs_ff[0]}, 21)
            / {16'h0000, $past({regs_ff[5], regs_ff[4]}, 21)}))) else $error("Divide quotient wrong");
    div_rem_a: assert property (@(posedge i_clock) disable iff (i_rst)
        (div_start_s and (({regs_ff[5], regs_ff[4]} != 16'h0000)
        && ({regs_ff[3], regs_ff[2]} < {regs_ff[5], regs_ff[4]})))
        |-> ##21 ({regs_ff[3], regs_ff[2]} == 16'($past({regs_ff[3], regs_ff[2], regs_ff[1], regs_ff[0]}, 21)
            % {16'h0000, $past({regs_ff[5], regs_ff[4]}, 21)}))) else $error("Divide remainder wrong");
    done_clear_a: assert property (@(posedge i_clock) disable iff (i_rst)
        start |=> !o_done && o_busy) else $error("Done not cleared at start");
    done_set_a: assert property (@(posedge i_clock) disable iff (i_rst)
        finish |=> o_done && !o_busy) else $error("Done not set at completion");
    bank_only_a: assert property (@(posedge i_clock) disable iff (i_rst)
        i_req.wr && (i_req.bank != `MDU_BANK) && (state_ff == MDU_IDLE)
        |=> $stable(regs_ff[0]) && (state_ff == MDU_IDLE)) else $error("Write outside bank changed unit");
    operand_hold_a: assert property (@(posedge i_clock) disable iff (i_rst)
        mul_start_s ##2 (i_req.wr && hit && i_req.addr == `MDU_OFS_OP0) |-> ##15 finish)
        else $error("Operand write disturbed run");
    scratch_wr_a: assert property (@(posedge i_clock) disable iff (i_rst)
        hit && i_req.wr && i_req.addr == `MDU_OFS_SCR_A |=> scr_a_ff == $past(i_req.wdata))
        else $error("Scratch byte not written");
endmodule // mdu_unit

// ===== verif/mdu_core_model.sv
// Purpose: Core side of the register port, issuing direct byte reads and writes
// Assumes: One access at a time, inputs changed 1 ns after the rising edge
// Notes: Released bank, address and data lines carry inverted values and the strobes go low, so stale data cannot pass
`timescale 1ns/1ps
module mdu_core_model
    import mdu_pkg::*;
(
    input wire logic i_clock,
    output mdu_req_s o_req,
    input wire logic [7:0] i_rdata
);
    initial begin
        o_req = '0;
    end
    task automatic access(input logic [3:0] bk, input logic [7:0] a, input logic w, input logic [7:0] d);
        @(posedge i_clock);
        #1;
        o_req = '{bank: bk, addr: a, wr: w, rd: ~w, wdata: d};
        @(posedge i_clock);
        #1;
        o_req = '{bank: ~bk, addr: ~a, wr: 1'b0, rd: 1'b0, wdata: ~d};
    endtask
    task automatic write(input logic [3:0] bk, input logic [7:0] a, input logic [7:0] d);
        access(bk, a, 1'b1, d);
    endtask
    // Read data stands one cycle only, so it is taken right after the edge
    task automatic read(input logic [3:0] bk, input logic [7:0] a, output logic [7:0] d);
        access(bk, a, 1'b0, 8'h00);
        d = i_rdata;
    endtask
endmodule // mdu_core_model

// ===== verif/mdu_unit_tb.sv
// Purpose: Self-checking bench of the multiply/divide unit
// Assumes: Core model drives every register access
// Notes: Latency counted in edges after the start write is taken
`timescale 1ns/1ps
`include "mdu_cfg.svh"
`define CHK(nm, ex, got) begin num_checks++; if ((got) !== (ex)) begin err_total++; \
    $display("[ERR] %s exp %h got %h", nm, ex, got); end end
module mdu_unit_tb;
    import mdu_pkg::*;
    logic i_clock;
    logic i_rst;
    mdu_req_s i_req;
    logic [7:0] o_rdata;
    logic o_busy;
    logic o_done;
    int err_total;
    int num_checks;
    int cyc;
    int n;
    logic [7:0] rb;
    logic [31:0] res;
    logic [31:0] dd;
    logic [15:0] dv;
    mdu_unit mdu_unit_inst (.i_clock(i_clock), .i_rst(i_rst), .i_req(i_req), .o_rdata(o_rdata),
        .o_busy(o_busy), .o_done(o_done));
    mdu_core_model mdu_core_model_inst (.i_clock(i_clock), .o_req(i_req), .i_rdata(o_rdata));
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        mdu_core_model_inst.write(`MDU_BANK, a, d);
    endtask
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        mdu_core_model_inst.read(`MDU_BANK, a, d);
    endtask
    task automatic load(input logic [47:0] v);
        for (int i = 0; i < 6; i++) begin
            wr(8'(i), v[8*i +: 8]);
        end
    endtask
    task automatic wait_done();
        n = 0;
        while (o_done !== 1'b1 && n < 60) begin
            @(posedge i_clock);
            #1;
            n++;
        end
    endtask
    task automatic get32(output logic [31:0] v);
        logic [7:0] b;
        for (int i = 0; i < 4; i++) begin
            rd(8'(i), b);
            v[8*i +: 8] = b;
        end
    endtask
    task automatic run(input logic dsel, input logic [47:0] ops, input logic [31:0] ex);
        load(ops);
        wr(`MDU_OFS_CTRL, {6'h00, 1'b1, dsel});
        `CHK("busy at start", 1'b1, o_busy)
        `CHK("done at start", 1'b0, o_done)
        wait_done();
        `CHK("latency", dsel ? 32'(`MDU_DIV_CYCLES) : 32'(`MDU_MUL_CYCLES), 32'(n))
        `CHK("busy at end", 1'b0, o_busy)
        rd(`MDU_OFS_CTRL, rb);
        `CHK("ctrl at end", 8'h80, rb & 8'hC2)
        get32(res);
        `CHK("result", ex, res)
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", num_checks, err_total);
        if (err_total == 0 && num_checks > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    initial begin
        i_clock = 1'b0;
        forever #4 i_clock = ~i_clock;
    end
    // Whole run needs about 150 cycles; far above that means a hang
    initial begin
        cyc = 0;
        forever begin
            @(posedge i_clock);
            cyc++;
            if (cyc == 3000) begin
                err_total++;
                wrap_up();
            end
        end
    end
    initial begin
        err_total = 0;
        num_checks = 0;
        i_rst = 1'b1;
        repeat (6) @(posedge i_clock);
        #1;
        i_rst = 1'b0;
        `CHK("busy after reset", 1'b0, o_busy)
        `CHK("done after reset", 1'b0, o_done)
        rd(`MDU_OFS_CTRL, rb);
        `CHK("ctrl after reset", 8'h00, rb)
        wr(`MDU_OFS_SCR_A, 8'hA5);
        wr(`MDU_OFS_SCR_B, 8'h5A);
        wr(`MDU_OFS_OP5, 8'hC3);
        rd(`MDU_OFS_SCR_A, rb);
        `CHK("scratch a", 8'hA5, rb)
        rd(`MDU_OFS_SCR_B, rb);
        `CHK("scratch b", 8'h5A, rb)
        rd(`MDU_OFS_OP5, rb);
        `CHK("operand 5", 8'hC3, rb)
        rd(8'h07, rb);
        `CHK("unmapped", 8'h00, rb)
        mdu_core_model_inst.read(4'hD, `MDU_OFS_SCR_A, rb);
        `CHK("other bank", 8'h00, rb)
        mdu_core_model_inst.write(4'hD, `MDU_OFS_OP0, 8'hFF);
        rd(`MDU_OFS_OP0, rb);
        `CHK("other bank write", 8'h00, rb)
        run(1'b0, {16'h0000, 16'hFFFF, 16'hFFFF}, 32'hFFFE0001);
        dd = 32'h80000005;
        dv = 16'h8001;
        run(1'b1, {dv, dd}, {16'(dd % dv), 16'(dd / dv)});
        // Mid-run writes: operand change and divide restart must not disturb the product
        load({16'h0000, 16'h0003, 16'h0005});
        wr(`MDU_OFS_CTRL, 8'h02);
        wr(`MDU_OFS_OP0, 8'h07);
        wr(`MDU_OFS_CTRL, 8'h03);
        rd(`MDU_OFS_CTRL, rb);
        `CHK("ctrl while busy", 8'h40, rb & 8'hC1)
        wait_done();
        get32(res);
        `CHK("product after refused writes", 32'h0000000F, res)
        wrap_up();
    end
endmodule // mdu_unit_tb
